// file: otl_pkg.sv
// shared constants for the display command interpreter
package otl_pkg;
  localparam logic [7:0] CMD_CLOCK_SET   = 8'hD5;
  localparam logic [7:0] CMD_PRECHARGE   = 8'hD9;
  localparam logic [7:0] CMD_SEG_CONFIG  = 8'hDA;
  localparam logic [7:0] CMD_DESELECT    = 8'hDB;
  localparam logic [7:0] CMD_NOP         = 8'hE3;
  localparam logic [7:0] CMD_LOCK        = 8'hFD;
  localparam logic [7:0] CMD_HSCROLL_R   = 8'h26;
  localparam logic [7:0] CMD_HSCROLL_L   = 8'h27;
  localparam logic [7:0] CMD_VHSCROLL_R  = 8'h29;
  localparam logic [7:0] CMD_VHSCROLL_L  = 8'h2A;
  localparam logic [7:0] CMD_SCROLL_OFF  = 8'h2E;
  localparam logic [7:0] CMD_SCROLL_ON   = 8'h2F;
  localparam logic [7:0] CMD_SEG_REMAP0  = 8'hA0;
  localparam logic [7:0] CMD_SEG_REMAP1  = 8'hA1;
  localparam logic [7:0] CMD_RAM_WRITE   = 8'h5C;
  localparam logic [7:0] ARG_UNLOCK      = 8'h12;
  localparam logic [7:0] ARG_LOCK        = 8'h16;
  localparam int         LOCK_BIT        = 2;
  localparam int         ORDER_BIT       = 4;
  localparam int         SWAP_BIT        = 5;
  localparam int         HOFS_BIT        = 0;
  localparam int         SCROLL_ARGS     = 7;
  localparam int         VOFS_IDX        = 4;
  localparam logic [3:0] DIV_RST         = 4'h0;
  localparam logic [3:0] OSC_RST         = 4'h0;
  localparam logic [7:0] PRECHARGE_RST   = 8'h02;
  localparam logic [7:0] DESELECT_RST    = 8'h00;
  localparam logic       ORDER_RST       = 1'b1;
  localparam logic [6:0] FULL_END_COL    = 7'h7F;
  localparam int         SCROLL_COLS     = 128;
  typedef enum logic [1:0] {
    OTL_SCR_H,
    OTL_SCR_V,
    OTL_SCR_DIAG
  } otl_scroll_mode_t;
endpackage

// file: otl_link_if.sv
// byte link between host and display command interpreter
`timescale 1ns/1ps
interface otl_link_if;
  logic       valid;
  logic       is_cmd;
  logic [7:0] data;
  logic       ready;
  modport device (input valid, input is_cmd, input data, output ready);
  modport host   (output valid, output is_cmd, output data, input ready);
endinterface

// file: otl_device.sv
// display driver command interpreter: timing, lock and scroll settings
`timescale 1ns/1ps
module otl_device #(
  parameter int DIV_W = 4
) (
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_i,
  otl_link_if.device                     link,
  input  wire logic                      clock_source_select_i,
  input  wire logic                      ext_clk_en_i,
  output logic                           display_clock_en_o,
  output logic [3:0]                     osc_freq_o,
  output logic                           osc_in_use_o,
  output logic                           precharge_active_o,
  output logic                           seg_odd_even_o,
  output logic                           seg_swap_o,
  output logic                           seg_remap_o,
  output logic [7:0]                     common_deselect_level_o,
  output logic                           locked_o,
  output logic                           scroll_active_o,
  output otl_pkg::otl_scroll_mode_t      scroll_mode_o,
  output logic                           scroll_left_o,
  output logic [7:0]                     scroll_arg_o [otl_pkg::SCROLL_ARGS],
  output logic                           mem_write_o,
  output logic [7:0]                     mem_data_o
);
  typedef enum logic [1:0] {OTL_IDLE, OTL_ARG1, OTL_ARGN} otl_dec_t;

  otl_dec_t   st_r, st_nxt;
  logic [7:0] op_r, op_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic [3:0] div_r, div_nxt;
  logic [3:0] osc_r, osc_nxt;
  logic [7:0] pre_r, pre_nxt;
  logic       ord_r, ord_nxt;
  logic       swp_r, swp_nxt;
  logic       rmp_r, rmp_nxt;
  logic [7:0] dsl_r, dsl_nxt;
  logic       lck_r, lck_nxt;
  logic       act_r, act_nxt;
  logic       lft_r, lft_nxt;
  logic       vh_r, vh_nxt;
  logic [7:0] arg_r [otl_pkg::SCROLL_ARGS];
  logic [7:0] arg_nxt [otl_pkg::SCROLL_ARGS];
  logic       mw_r, mw_nxt;
  logic [7:0] md_r, md_nxt;
  logic       take;

  assign link.ready = 1'b1;
  assign take       = link.valid;

  always_comb begin
    st_nxt  = st_r;
    op_nxt  = op_r;
    idx_nxt = idx_r;
    div_nxt = div_r;
    osc_nxt = osc_r;
    pre_nxt = pre_r;
    ord_nxt = ord_r;
    swp_nxt = swp_r;
    rmp_nxt = rmp_r;
    dsl_nxt = dsl_r;
    lck_nxt = lck_r;
    act_nxt = act_r;
    lft_nxt = lft_r;
    vh_nxt  = vh_r;
    arg_nxt = arg_r;
    mw_nxt  = 1'b0;
    md_nxt  = md_r;
    if (take && !link.is_cmd) begin
      if (!lck_r) begin
        mw_nxt = 1'b1;
        md_nxt = link.data;
      end
    end else if (take) begin
      case (st_r)
        OTL_IDLE: begin
          op_nxt  = link.data;
          idx_nxt = 3'h0;
          // locked: only the lock command passes
          if (lck_r && link.data != otl_pkg::CMD_LOCK) begin
            st_nxt = OTL_IDLE;
          end else begin
            case (link.data)
              otl_pkg::CMD_CLOCK_SET, otl_pkg::CMD_PRECHARGE, otl_pkg::CMD_SEG_CONFIG,
              otl_pkg::CMD_DESELECT, otl_pkg::CMD_LOCK: st_nxt = OTL_ARG1;
              otl_pkg::CMD_HSCROLL_R, otl_pkg::CMD_HSCROLL_L,
              otl_pkg::CMD_VHSCROLL_R, otl_pkg::CMD_VHSCROLL_L: st_nxt = OTL_ARGN;
              otl_pkg::CMD_SCROLL_OFF: act_nxt = 1'b0;
              otl_pkg::CMD_SCROLL_ON: act_nxt = 1'b1;
              otl_pkg::CMD_SEG_REMAP0: rmp_nxt = 1'b0;
              otl_pkg::CMD_SEG_REMAP1: rmp_nxt = 1'b1;
              otl_pkg::CMD_NOP: st_nxt = OTL_IDLE;
              default: st_nxt = OTL_IDLE;
            endcase
          end
        end
        OTL_ARG1: begin
          st_nxt = OTL_IDLE;
          case (op_r)
            otl_pkg::CMD_CLOCK_SET: begin
              div_nxt = link.data[3:0];
              osc_nxt = link.data[7:4];
            end
            otl_pkg::CMD_PRECHARGE: pre_nxt = link.data;
            otl_pkg::CMD_SEG_CONFIG: begin
              ord_nxt = link.data[otl_pkg::ORDER_BIT];
              swp_nxt = link.data[otl_pkg::SWAP_BIT];
            end
            otl_pkg::CMD_DESELECT: dsl_nxt = link.data;
            otl_pkg::CMD_LOCK: lck_nxt = link.data[otl_pkg::LOCK_BIT];
            default: st_nxt = OTL_IDLE;
          endcase
        end
        OTL_ARGN: begin
          // seven bytes for either setup form
          // last two bytes are columns, 0 to 127
          arg_nxt[idx_r] = (idx_r >= 3'(otl_pkg::SCROLL_ARGS - 2)) ?
            (link.data & {1'b0, otl_pkg::FULL_END_COL}) : link.data;
          idx_nxt = idx_r + 3'h1;
          if (idx_r == 3'(otl_pkg::SCROLL_ARGS - 1)) begin
            st_nxt = OTL_IDLE;
            // newest setup overwrites mode and direction
            vh_nxt  = (op_r == otl_pkg::CMD_VHSCROLL_R) || (op_r == otl_pkg::CMD_VHSCROLL_L);
            lft_nxt = (op_r == otl_pkg::CMD_HSCROLL_L) || (op_r == otl_pkg::CMD_VHSCROLL_L);
          end
        end
        default: st_nxt = OTL_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r  <= OTL_IDLE;
      op_r  <= 8'h00;
      idx_r <= 3'h0;
      div_r <= otl_pkg::DIV_RST;
      osc_r <= otl_pkg::OSC_RST;
      pre_r <= otl_pkg::PRECHARGE_RST;
      ord_r <= otl_pkg::ORDER_RST;
      swp_r <= 1'b0;
      rmp_r <= 1'b0;
      dsl_r <= otl_pkg::DESELECT_RST;
      lck_r <= 1'b0;
      act_r <= 1'b0;
      lft_r <= 1'b0;
      vh_r  <= 1'b0;
      arg_r <= '{default: 8'h00};
      mw_r  <= 1'b0;
      md_r  <= 8'h00;
    end else begin
      st_r  <= st_nxt;
      op_r  <= op_nxt;
      idx_r <= idx_nxt;
      div_r <= div_nxt;
      osc_r <= osc_nxt;
      pre_r <= pre_nxt;
      ord_r <= ord_nxt;
      swp_r <= swp_nxt;
      rmp_r <= rmp_nxt;
      dsl_r <= dsl_nxt;
      lck_r <= lck_nxt;
      act_r <= act_nxt;
      lft_r <= lft_nxt;
      vh_r  <= vh_nxt;
      arg_r <= arg_nxt;
      mw_r  <= mw_nxt;
      md_r  <= md_nxt;
    end
  end

  // clock source and display clock divider
  logic       cls_s1_r, cls_s2_r;
  logic [DIV_W-1:0] dcnt_r, dcnt_nxt;
  logic       den_r, den_nxt;
  logic       src_en;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cls_s1_r <= 1'b0;
      cls_s2_r <= 1'b0;
    end else begin
      cls_s1_r <= clock_source_select_i;
      cls_s2_r <= cls_s1_r;
    end
  end
  // internal oscillator only with select high
  assign src_en = cls_s2_r ? 1'b1 : ext_clk_en_i;

  always_comb begin
    dcnt_nxt = dcnt_r;
    den_nxt  = 1'b0;
    if (src_en) begin
      if (dcnt_r >= DIV_W'(div_r)) begin
        dcnt_nxt = '0;
        den_nxt  = 1'b1;
      end else begin
        dcnt_nxt = dcnt_r + DIV_W'(1);
      end
    end
  end

  // pre-charge timer; phase flips each period, drive phase mirrors its length
  logic [7:0] pcnt_r, pcnt_nxt;
  logic       ph_r, ph_nxt;
  always_comb begin
    pcnt_nxt = pcnt_r;
    ph_nxt   = ph_r;
    if (den_r) begin
      pcnt_nxt = (pcnt_r + 8'h01 >= pre_r) ? 8'h00 : pcnt_r + 8'h01;
      ph_nxt   = (pcnt_r + 8'h01 >= pre_r) ? !ph_r : ph_r;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dcnt_r <= '0;
      den_r  <= 1'b0;
      pcnt_r <= 8'h00;
      ph_r   <= 1'b0;
    end else begin
      dcnt_r <= dcnt_nxt;
      den_r  <= den_nxt;
      pcnt_r <= pcnt_nxt;
      ph_r   <= ph_nxt;
    end
  end

  assign display_clock_en_o      = den_r;
  assign osc_freq_o              = osc_r;
  assign osc_in_use_o            = cls_s2_r;
  assign precharge_active_o      = ph_r;
  assign seg_odd_even_o          = ord_r;
  assign seg_swap_o              = swp_r;
  assign seg_remap_o             = rmp_r;
  assign common_deselect_level_o = dsl_r;
  assign locked_o                = lck_r;
  assign scroll_active_o         = act_r;
  assign scroll_left_o           = lft_r;
  assign scroll_arg_o            = arg_r;
  assign mem_write_o             = mw_r;
  assign mem_data_o              = md_r;

  // zero vertical offset gives horizontal; no column bit vertical
  always_comb begin
    if (!vh_r || arg_r[otl_pkg::VOFS_IDX][3:0] == 4'h0) begin
      scroll_mode_o = otl_pkg::OTL_SCR_H;
    end else if (!arg_r[0][otl_pkg::HOFS_BIT]) begin
      scroll_mode_o = otl_pkg::OTL_SCR_V;
    end else begin
      scroll_mode_o = otl_pkg::OTL_SCR_DIAG;
    end
  end
endmodule

// file: otl_host.sv
// host end: sends commands, guards scroll setup and memory writes
`timescale 1ns/1ps
module otl_host (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  otl_link_if.host         link,
  input  wire logic        req_valid_i,
  input  wire logic        req_is_cmd_i,
  input  wire logic [7:0]  req_data_i,
  output logic             req_ready_o,
  output logic             scroll_on_o
);
  typedef enum logic [1:0] {OTH_PASS, OTH_STOP} otl_hst_t;
  otl_hst_t   st_r, st_nxt;
  logic       on_r, on_nxt;
  logic       v_r, v_nxt;
  logic       c_r, c_nxt;
  logic [7:0] d_r, d_nxt;
  logic       setup_cmd;

  assign setup_cmd = req_is_cmd_i && (req_data_i == otl_pkg::CMD_HSCROLL_R ||
    req_data_i == otl_pkg::CMD_HSCROLL_L || req_data_i == otl_pkg::CMD_VHSCROLL_R ||
    req_data_i == otl_pkg::CMD_VHSCROLL_L);
  // data bytes wait too, else the inserted stop would swallow them
  assign req_ready_o = (!v_r || link.ready) && st_r == OTH_PASS &&
    !(on_r && (setup_cmd || !req_is_cmd_i));

  always_comb begin
    st_nxt = st_r;
    on_nxt = on_r;
    v_nxt  = v_r && !link.ready;
    c_nxt  = c_r;
    d_nxt  = d_r;
    case (st_r)
      OTH_PASS: begin
        if (!v_r || link.ready) begin
          if (req_valid_i && on_r && (setup_cmd || !req_is_cmd_i)) begin
            // stop scroll before setup or memory
            v_nxt  = 1'b1;
            c_nxt  = 1'b1;
            d_nxt  = otl_pkg::CMD_SCROLL_OFF;
            on_nxt = 1'b0;
            st_nxt = OTH_STOP;
          end else if (req_valid_i) begin
            v_nxt = 1'b1;
            c_nxt = req_is_cmd_i;
            d_nxt = req_data_i;
            if (req_is_cmd_i && req_data_i == otl_pkg::CMD_SCROLL_ON) on_nxt = 1'b1;
            if (req_is_cmd_i && req_data_i == otl_pkg::CMD_SCROLL_OFF) on_nxt = 1'b0;
          end
        end
      end
      OTH_STOP: begin
        if (!v_r || link.ready) st_nxt = OTH_PASS;
      end
      default: st_nxt = OTH_PASS;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= OTH_PASS;
      on_r <= 1'b0;
      v_r  <= 1'b0;
      c_r  <= 1'b0;
      d_r  <= 8'h00;
    end else begin
      st_r <= st_nxt;
      on_r <= on_nxt;
      v_r  <= v_nxt;
      c_r  <= c_nxt;
      d_r  <= d_nxt;
    end
  end

  assign link.valid  = v_r;
  assign link.is_cmd = c_r;
  assign link.data   = d_r;
  assign scroll_on_o = on_r;
endmodule

// file: otl_link_sva.sv
// link checker: decode of oscillator, segment and deselect arguments, lock and scroll control
`timescale 1ns/1ps
module otl_link_sva (
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic       valid,
  input wire logic       is_cmd,
  input wire logic [7:0] data,
  input wire logic       locked_o,
  input wire logic       mem_write_o,
  input wire logic       scroll_active_o,
  input wire logic [3:0] osc_freq_o,
  input wire logic       seg_odd_even_o,
  input wire logic       seg_swap_o,
  input wire logic [7:0] common_deselect_level_o
);
  logic [7:0] op_r;
  logic [2:0] left_r;
  logic       cmd_w;
  logic       arg_w;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  assign cmd_w = valid && is_cmd && (left_r == 3'h0);
  assign arg_w = valid && is_cmd && (left_r == 3'h1);
  // argument count kept so arguments are never taken for opcodes
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      op_r   <= 8'h00;
      left_r <= 3'h0;
    end else if (cmd_w) begin
      op_r   <= data;
      left_r <= (data inside {8'hD5, 8'hD9, 8'hDA, 8'hDB, 8'hFD}) ? 3'h1 :
                (data inside {8'h26, 8'h27, 8'h29, 8'h2A}) ? 3'h7 : 3'h0;
    end else if (valid && is_cmd) begin
      left_r <= left_r - 3'h1;
    end
  end
  sequence s_cmd(logic [7:0] c);
    cmd_w && (data == c) && !locked_o;
  endsequence
  sequence s_arg(logic [7:0] c);
    arg_w && (op_r == c);
  endsequence
  a_osc_nibble: assert property (s_arg(8'hD5) ##0 !locked_o |=>
    {osc_freq_o, 4'h0} == ($past(data) & 8'hF0)) else $error("osc freq not from argument");
  a_seg_bits: assert property (s_arg(8'hDA) ##0 !locked_o |=>
    {seg_swap_o, seg_odd_even_o} == 2'($past(data) >> 4)) else $error("segment bits wrong");
  a_deselect_level: assert property (s_arg(8'hDB) ##0 !locked_o |=>
    common_deselect_level_o == $past(data)) else $error("deselect level wrong");
  a_lock_enter: assert property (s_arg(8'hFD) ##0 data[2] |=> locked_o)
    else $error("lock not entered");
  a_lock_leave: assert property (s_arg(8'hFD) ##0 !data[2] |=> !locked_o)
    else $error("lock not left");
  a_locked_hold: assert property (locked_o && arg_w && (op_r != 8'hFD) |=>
    $stable(common_deselect_level_o) && $stable(osc_freq_o) && locked_o)
    else $error("setting changed while locked");
  a_locked_nomem: assert property (locked_o && valid && !is_cmd |=> !mem_write_o)
    else $error("memory written while locked");
  a_mem_write: assert property (!locked_o && valid && !is_cmd |=> mem_write_o)
    else $error("memory write missing");
  a_scroll_stop: assert property (s_cmd(8'h2E) |=> !scroll_active_o)
    else $error("scroll not stopped");
  a_scroll_start: assert property (s_cmd(8'h2F) |=> scroll_active_o)
    else $error("scroll not started");
  a_reset_state: assert property ($fell(rst_i) |-> osc_freq_o == 4'h0 && seg_odd_even_o
    && !seg_swap_o && !locked_o && !scroll_active_o && common_deselect_level_o == 8'h00)
    else $error("reset state wrong");
endmodule

// file: test_oled_timing_lock_scroll_cmds.sv
// self-checking bench for the host and device command pair
`timescale 1ns/1ps
module test_oled_timing_lock_scroll_cmds;
  logic                       core_clk_i, rst_i, sel, ext_en;
  logic                       req_valid_i, req_is_cmd_i, req_ready_o, scroll_on_o;
  logic [7:0]                 req_data_i;
  logic                       display_clock_en, osc_use, pre_act, odd_even, swap, remap;
  logic [3:0]                 osc_freq;
  logic [7:0]                 level, mem_data, mw_last;
  logic                       locked, act, left, mem_wr;
  otl_pkg::otl_scroll_mode_t  mode;
  logic [7:0]                 sarg [otl_pkg::SCROLL_ARGS];
  int                         fails, checked, mw_cnt;
  bit                         at_edge;
  otl_link_if otl_link_if_i ();
  otl_host otl_host_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(otl_link_if_i.host),
    .req_valid_i(req_valid_i), .req_is_cmd_i(req_is_cmd_i), .req_data_i(req_data_i),
    .req_ready_o(req_ready_o), .scroll_on_o(scroll_on_o));
  otl_device otl_device_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .link(otl_link_if_i.device),
    .clock_source_select_i(sel), .ext_clk_en_i(ext_en), .display_clock_en_o(display_clock_en),
    .osc_freq_o(osc_freq), .osc_in_use_o(osc_use), .precharge_active_o(pre_act),
    .seg_odd_even_o(odd_even), .seg_swap_o(swap), .seg_remap_o(remap),
    .common_deselect_level_o(level), .locked_o(locked), .scroll_active_o(act),
    .scroll_mode_o(mode), .scroll_left_o(left), .scroll_arg_o(sarg),
    .mem_write_o(mem_wr), .mem_data_o(mem_data));
  otl_link_sva otl_link_sva_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .valid(otl_link_if_i.valid), .is_cmd(otl_link_if_i.is_cmd), .data(otl_link_if_i.data),
    .locked_o(locked), .mem_write_o(mem_wr), .scroll_active_o(act), .osc_freq_o(osc_freq),
    .seg_odd_even_o(odd_even), .seg_swap_o(swap), .common_deselect_level_o(level));
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  // sampled mid-cycle: a one-cycle pulse is seen exactly once
  always @(negedge core_clk_i) begin
    if (mem_wr === 1'b1) begin
      mw_cnt++;
      mw_last = mem_data;
    end
  end
  task give_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // leaves valid up so back-to-back bytes need no extra edge
  task send(input logic c, input logic [7:0] d);
    int n;
    if (!at_edge) @(posedge core_clk_i);
    req_valid_i <= 1'b1;
    req_is_cmd_i <= c;
    req_data_i <= d;
    for (n = 0; n < 50; n++) begin
      @(negedge core_clk_i);
      if (req_ready_o === 1'b1) break;
    end
    if (n == 50) begin
      fails++;
      give_verdict();
    end
    @(posedge core_clk_i);
    at_edge = 1'b1;
  endtask
  task idle(input int n);
    req_valid_i <= 1'b0;
    repeat (n) @(posedge core_clk_i);
    @(negedge core_clk_i);
    at_edge = 1'b0;
  endtask
  task cmd(input logic [7:0] op, input logic [7:0] a);
    send(1'b1, op);
    send(1'b1, a);
    idle(6);
  endtask
  task dcnt(input int n, input logic [7:0] e);
    int k;
    k = 0;
    repeat (n) begin
      @(negedge core_clk_i);
      if (display_clock_en === 1'b1) k++;
    end
    chk("display_clock", e, 8'(k));
  endtask
  // skips one full period, both phases, so a changed length has settled
  task pcheck(input int n, input logic [7:0] e);
    int k;
    k = 0;
    repeat (24) @(negedge core_clk_i);
    repeat (n) begin
      @(negedge core_clk_i);
      if (pre_act === 1'b1) k++;
    end
    chk("precharge", e, 8'(k));
  endtask
  task scroll(input logic [7:0] op, input logic [7:0] a0, input logic [7:0] e);
    send(1'b1, op);
    foreach (sarg[i]) send(1'b1, (i == 0) ? a0 : (i == 4) ? e : (i == 6) ? 8'hFF : 8'(i));
    idle(6);
    chk("arg0", a0, sarg[0]);
    chk("arg4", e, sarg[4]);
    chk("arg6", 8'h7F, sarg[6]);
  endtask
  initial begin
    {fails, checked, mw_cnt} = '0;
    rst_i = 1'b1;
    {sel, req_valid_i, req_is_cmd_i, at_edge} = '0;
    ext_en = 1'b1;
    req_data_i = 8'h00;
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(negedge core_clk_i);
    chk("osc", 8'h00, osc_freq);
    chk("order", 8'h01, odd_even);
    chk("remap", 8'h00, {swap, remap});
    dcnt(20, 8'd20);
    cmd(8'hD5, 8'hA2);
    chk("osc", 8'h0A, osc_freq);
    dcnt(30, 8'd10);
    @(posedge core_clk_i);
    sel <= 1'b1;
    idle(4);
    chk("osc_use", 8'h01, osc_use);
    cmd(8'hD9, 8'h04);
    pcheck(240, 8'd120);
    $display("test clock done");
    for (int i = 0; i < 8; i++) begin
      cmd(8'hDA, {2'b00, i[1], i[0], 4'h0});
      send(1'b1, i[2] ? 8'hA1 : 8'hA0);
      idle(4);
      chk("seg", 8'(i), {remap, swap, odd_even});
    end
    cmd(8'hDB, 8'h3C);
    send(1'b1, 8'hE3);
    idle(4);
    chk("level", 8'h3C, level);
    $display("test segment done");
    cmd(8'hFD, 8'h04);
    chk("locked", 8'h01, locked);
    cmd(8'hDB, 8'h55);
    send(1'b0, 8'hAA);
    idle(4);
    chk("level", 8'h3C, level);
    chk("writes", 8'h00, 8'(mw_cnt));
    cmd(8'hFD, 8'h12);
    send(1'b0, 8'h5A);
    idle(4);
    chk("locked", 8'h00, locked);
    chk("writes", 8'h5A, mw_last);
    $display("test lock done");
    scroll(8'h29, 8'h01, 8'h03);
    chk("mode", 8'(otl_pkg::OTL_SCR_DIAG), 8'(mode));
    send(1'b1, 8'h2F);
    idle(6);
    chk("active", 8'h03, {scroll_on_o, act});
    scroll(8'h27, 8'h00, 8'h05);
    chk("active", 8'h00, act);
    chk("left", 8'h01, left);
    send(1'b1, 8'h2F);
    idle(6);
    scroll(8'h2A, 8'h00, 8'h02);
    chk("active", 8'h00, act);
    chk("mode", 8'(otl_pkg::OTL_SCR_V), 8'(mode));
    send(1'b1, 8'h2F);
    send(1'b0, 8'hC3);
    idle(6);
    chk("active", 8'h00, {scroll_on_o, act});
    chk("writes", 8'hC3, mw_last);
    scroll(8'h29, 8'h01, 8'h00);
    chk("mode", 8'(otl_pkg::OTL_SCR_H), 8'(mode));
    send(1'b1, 8'h2F);
    send(1'b1, 8'h2E);
    idle(6);
    chk("active", 8'h00, act);
    $display("test scroll done");
    cmd(8'hFD, 8'h16);
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(negedge core_clk_i);
    chk("locked", 8'h00, locked);
    chk("osc", 8'h00, osc_freq);
    chk("seg", 8'h01, {remap, swap, odd_even});
    dcnt(20, 8'd20);
    $display("test reset done");
    give_verdict();
  end
endmodule
